// ---- rtl/rgf_pkg.sv ----
// Shared constants and types for the receiver gain and filter controller
package rgf_pkg;

  // ---------------------------------------------------------------
  // Register map (word index on the plain register port)
  // ---------------------------------------------------------------
  localparam int         ADDR_W          = 3;
  localparam logic [2:0] ADDR_FILTER     = 3'h0;
  localparam logic [2:0] ADDR_FIRST_GAIN = 3'h1;
  localparam logic [2:0] ADDR_GAIN_CFG   = 3'h2;
  localparam logic [2:0] ADDR_RX_CTRL    = 3'h3;
  localparam logic [2:0] ADDR_MODE       = 3'h4;
  localparam logic [2:0] ADDR_GAIN_STATE = 3'h5;
  localparam logic [2:0] ADDR_COMMAND    = 3'h6;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] FILTER_RST      = 8'h00;
  localparam logic [7:0] FIRST_GAIN_RST  = 8'h06;
  localparam logic [7:0] GAIN_CFG_RST    = 8'h00;
  localparam logic [7:0] RX_CTRL_RST     = 8'h05;
  localparam logic [7:0] MODE_RST        = 8'h00;

  // ---------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------
  localparam int ZERO_LSB = 0;
  localparam int LP_LSB   = 3;
  localparam int FG_RED_LSB   = 0;
  localparam int FG_BOOST_BIT = 3;
  localparam int GC_WIN_LSB   = 0;
  localparam int GC_RED_LSB   = 4;
  localparam int RC_AGC_EN    = 0;
  localparam int RC_AGC_M     = 1;
  localparam int RC_AGC_ALG   = 2;
  localparam int MD_MODE_LSB  = 0;
  localparam int MD_RATE_LSB  = 4;

  // ---------------------------------------------------------------
  // Direct commands
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_RESET_GAIN = 8'h01;
  localparam logic [7:0] CMD_PRESET     = 8'h02;
  localparam logic [7:0] CMD_MASK_RX    = 8'h03;
  localparam logic [7:0] CMD_UNMASK_RX  = 8'h04;
  localparam logic [7:0] CMD_SQUELCH    = 8'h05;

  // ---------------------------------------------------------------
  // Gain step limits
  // ---------------------------------------------------------------
  localparam logic [2:0] FG_RED_MAX   = 3'h6;
  localparam logic [2:0] WIN_MAX      = 3'h4;
  localparam logic [2:0] RED23_MAX    = 3'h6;
  localparam logic [3:0] STEP_MAX     = 4'ha;
  localparam logic [3:0] STEP_PRESET  = 4'h4;
  localparam logic [3:0] AGC_PULSES   = 4'h8;
  localparam logic [1:0] SQ_TOGGLE_OK = 2'h2;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ        = 250;
  localparam int SQ_WINDOW_US   = 50;
  localparam int SQ_WINDOW_CYC  = SQ_WINDOW_US * CLK_MHZ;

  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    RGF_MODE_ISO_A   = 4'h0,
    RGF_MODE_ISO_B   = 4'h1,
    RGF_MODE_P2P_ACT = 4'h2,
    RGF_MODE_STREAM  = 4'h3,
    RGF_MODE_TRANSP  = 4'h4
  } rgf_mode_t;

  typedef enum logic [2:0] {
    RGF_RATE_128 = 3'h0,
    RGF_RATE_64  = 3'h1,
    RGF_RATE_32  = 3'h2,
    RGF_RATE_16  = 3'h3,
    RGF_RATE_8   = 3'h4,
    RGF_RATE_4   = 3'h5
  } rgf_rate_t;

  // First zero: 0=60k 1=40k 2=12k; third zero: 0=400k 1=200k 2=80k
  localparam logic [1:0] Z1_60K  = 2'h0;
  localparam logic [1:0] Z1_40K  = 2'h1;
  localparam logic [1:0] Z1_12K  = 2'h2;
  localparam logic [1:0] Z3_400K = 2'h0;
  localparam logic [1:0] Z3_200K = 2'h1;
  localparam logic [1:0] Z3_80K  = 2'h2;

  // Low-pass corner select codes
  localparam logic [2:0] LP_1200K = 3'h0;
  localparam logic [2:0] LP_600K  = 3'h1;
  localparam logic [2:0] LP_300K  = 3'h3;
  localparam logic [2:0] LP_2M    = 3'h4;
  localparam logic [2:0] LP_7M    = 3'h5;

  // Zero option bits inside the filter field
  localparam logic [2:0] ZB_NONE  = 3'h0;
  localparam logic [2:0] ZB_MID   = 3'h4;
  localparam logic [2:0] ZB_LOW   = 3'h2;
  localparam logic [2:0] ZB_MID_L = 3'h5;

endpackage

// ---- rtl/rgf_sq_if.sv ----
// Link between the controller and its squelch transition monitor
`timescale 1ns/1ps
`default_nettype none
interface rgf_sq_if;
  logic enable;
  logic dig;
  logic too_many;
  logic quiet;
  modport ctl (output enable, output dig, input  too_many, input  quiet);
  modport mon (input  enable, input  dig, output too_many, output quiet);
endinterface
`default_nettype wire

// ---- rtl/rgf_squelch_mon.sv ----
// Counts digitizer transitions per observation window
`timescale 1ns/1ps
`default_nettype none
module rgf_squelch_mon
  import rgf_pkg::*;
#(
  parameter int WINDOW_CYC = SQ_WINDOW_CYC
) (
  input  wire logic clk,
  input  wire logic resetn,
  rgf_sq_if.mon     sq
);

  logic [15:0] win_cnt;
  logic [1:0]  tog_cnt;
  logic        dig_d;
  logic        win_end;

  assign win_end = (win_cnt == 16'(WINDOW_CYC - 1));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dig_d <= 1'b0;
    end else begin
      dig_d <= sq.dig;
    end
  end

  // ---------------------------------------------------------------
  // Window timer and transition count
  // ---------------------------------------------------------------
  // window counting
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      win_cnt <= 16'h0000;
      tog_cnt <= 2'h0;
    end else if (!sq.enable || win_end) begin
      win_cnt <= 16'h0000;
      tog_cnt <= 2'h0;
    end else begin
      win_cnt <= win_cnt + 16'h0001;
      // Saturates at three: only "more than two" matters
      if ((sq.dig != dig_d) && (tog_cnt != 2'h3)) begin
        tog_cnt <= tog_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sq.too_many <= 1'b0;
      sq.quiet    <= 1'b0;
    end else begin
      sq.too_many <= sq.enable && win_end && (tog_cnt > SQ_TOGGLE_OK);
      sq.quiet    <= sq.enable && win_end && (tog_cnt <= SQ_TOGGLE_OK);
    end
  end

endmodule
`default_nettype wire

// ---- rtl/rgf_ctrl.sv ----
// Receiver filter, gain and AGC/squelch step controller
//
// Functional notes
// - First stage: six 2.5 dB cuts, boost option
// - First gain only by write; resets minimum
// - First zero 60k, options give 40k/12k
// - Filter bits 2..0 decode both zeros
// - Stage 2/3 gain, six 3 dB steps
// - Gain reset reloads shadow, clears squelch
// - Filter bits 5..3 select low-pass corner
// - Preset per mode/rate; none for stream/transparent
// - Preset values for peer mode and fc/8-4
// - Preset values for type A/B rates
// - Five digitizer windows, 3 dB apart
// - Eleven steps: window first, then gain
// - Start step comes from gain config
// - Gain state register shows step used
// - Receive window by timer or commands
// - AGC runs with window; fall captures state
// - Squelch cuts 3 dB per noisy window
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rgf_ctrl
  import rgf_pkg::*;
#(
  parameter int SQ_WIN_CYC = SQ_WINDOW_CYC
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic              mask_timer_expired,
  input  wire logic              digitizer_in,
  input  wire logic              agc_comp_in,
  output logic                   rx_on,
  output logic      [2:0]        first_gain_red,
  output logic                   first_gain_boost,
  output logic      [1:0]        first_zero_sel,
  output logic      [1:0]        third_zero_sel,
  output logic      [2:0]        lowpass_corner_sel,
  output logic      [2:0]        dig_window_sel,
  output logic      [2:0]        gain23_red
);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  // Step from a window/gain-reduction pair
  function automatic logic [3:0] step_of(input logic [2:0] win, input logic [2:0] red);
    logic [2:0] w;
    logic [2:0] r;
    w = (win > WIN_MAX) ? WIN_MAX : win;
    r = (red > RED23_MAX) ? RED23_MAX : red;
    if (r != 3'h0) begin
      step_of = {1'b0, WIN_MAX} + {1'b0, r};
    end else begin
      step_of = {1'b0, w};
    end
  endfunction

  function automatic logic [3:0] sat_add(input logic [3:0] a, input logic [3:0] b);
    logic [4:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = (s > {1'b0, STEP_MAX}) ? STEP_MAX : s[3:0];
  endfunction

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] receiver_filter_config;
  logic [7:0] first_gain_config;
  logic [7:0] gain_config;
  logic [7:0] rx_config;
  logic [7:0] mode_config;
  logic [3:0] gain_state;
  logic [3:0] shadow_step;
  logic [3:0] sq_red;
  logic [3:0] cur_step;
  logic [3:0] base_step;
  logic [3:0] agc_pulses;
  logic       rx_on_d;
  logic       sq_active;
  logic       agc_d;
  logic       agc_hit;
  logic       dig_d;
  logic       cmd_wr;
  logic       cmd_reset_gain;
  logic       cmd_preset;
  logic       preset_hit;
  logic [5:0] preset_val;
  logic [7:0] next_rdata;
  logic       dig_s1;
  logic       dig_s2;
  logic       agc_s1;
  logic       agc_s2;

  rgf_sq_if sq_link ();

  assign cmd_wr         = reg_wr && (reg_addr == ADDR_COMMAND);
  assign cmd_reset_gain = cmd_wr && (reg_wdata == CMD_RESET_GAIN);
  assign cmd_preset     = cmd_wr && (reg_wdata == CMD_PRESET);
  assign base_step      = sat_add(shadow_step, sq_red);
  assign agc_hit        = agc_s2 && !agc_d;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dig_s1 <= 1'b0;
      dig_s2 <= 1'b0;
      agc_s1 <= 1'b0;
      agc_s2 <= 1'b0;
      agc_d  <= 1'b0;
      dig_d  <= 1'b0;
    end else begin
      dig_s1 <= digitizer_in;
      dig_s2 <= dig_s1;
      agc_s1 <= agc_comp_in;
      agc_s2 <= agc_s1;
      agc_d  <= agc_s2;
      dig_d  <= dig_s2;
    end
  end

  // ---------------------------------------------------------------
  // Preset table
  // ---------------------------------------------------------------
  always_comb begin
    preset_hit = 1'b1;
    preset_val = {LP_1200K, ZB_NONE};
    unique case (rgf_mode_t'(mode_config[MD_MODE_LSB +: 4]))
      RGF_MODE_P2P_ACT: preset_val = {LP_1200K, ZB_MID_L};
      RGF_MODE_ISO_A: begin
        unique case (rgf_rate_t'(mode_config[MD_RATE_LSB +: 3]))
          RGF_RATE_128: preset_val = {LP_1200K, ZB_NONE};
          RGF_RATE_64:  preset_val = {LP_1200K, ZB_MID};
          RGF_RATE_32,
          RGF_RATE_16:  preset_val = {LP_2M, ZB_LOW};
          RGF_RATE_8,
          RGF_RATE_4:   preset_val = {LP_7M, ZB_MID};
          default:      preset_hit = 1'b0;
        endcase
      end
      RGF_MODE_ISO_B: begin
        unique case (rgf_rate_t'(mode_config[MD_RATE_LSB +: 3]))
          RGF_RATE_128,
          RGF_RATE_64:  preset_val = {LP_1200K, ZB_MID};
          RGF_RATE_32,
          RGF_RATE_16:  preset_val = {LP_2M, ZB_LOW};
          RGF_RATE_8,
          RGF_RATE_4:   preset_val = {LP_7M, ZB_MID};
          default:      preset_hit = 1'b0;
        endcase
      end
      // no preset in stream or transparent
      default: preset_hit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      receiver_filter_config <= FILTER_RST;
    end else if (cmd_preset && preset_hit) begin
      receiver_filter_config <= {receiver_filter_config[7:6], preset_val};
    end else if (reg_wr && (reg_addr == ADDR_FILTER)) begin
      receiver_filter_config <= reg_wdata;
    end
  end

  // only a write changes first gain
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      first_gain_config <= FIRST_GAIN_RST;
    end else if (reg_wr && (reg_addr == ADDR_FIRST_GAIN)) begin
      first_gain_config <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gain_config <= GAIN_CFG_RST;
      rx_config   <= RX_CTRL_RST;
      mode_config <= MODE_RST;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_GAIN_CFG) begin
        gain_config <= reg_wdata;
      end
      if (reg_addr == ADDR_RX_CTRL) begin
        rx_config <= reg_wdata;
      end
      if (reg_addr == ADDR_MODE) begin
        mode_config <= reg_wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // Receive window
  // ---------------------------------------------------------------
  // timer raises, commands force
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_on <= 1'b0;
    end else if (cmd_wr && (reg_wdata == CMD_MASK_RX)) begin
      rx_on <= 1'b0;
    end else if (mask_timer_expired || (cmd_wr && (reg_wdata == CMD_UNMASK_RX))) begin
      rx_on <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_on_d <= 1'b0;
    end else begin
      rx_on_d <= rx_on;
    end
  end

  // ---------------------------------------------------------------
  // Shadow and squelch reduction
  // ---------------------------------------------------------------
  // reload shadow from gain configuration
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shadow_step <= 4'h0;
    end else if (cmd_reset_gain) begin
      shadow_step <= step_of(gain_config[GC_WIN_LSB +: 3], gain_config[GC_RED_LSB +: 3]);
    end
  end

  // Squelch accepted only while the receive window is closed
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sq_active <= 1'b0;
    end else if (cmd_reset_gain || rx_on) begin
      sq_active <= 1'b0;
    end else if (cmd_wr && (reg_wdata == CMD_SQUELCH)) begin
      sq_active <= 1'b1;
    end else if (sq_link.quiet || (sq_link.too_many && (base_step == STEP_MAX))) begin
      sq_active <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sq_red <= 4'h0;
    end else if (cmd_reset_gain) begin
      sq_red <= 4'h0;
    end else if (sq_active && sq_link.too_many && (base_step != STEP_MAX)) begin
      sq_red <= sq_red + 4'h1;
    end
  end

  assign sq_link.enable = sq_active;
  assign sq_link.dig    = dig_s2;

  rgf_squelch_mon #(
    .WINDOW_CYC (SQ_WIN_CYC)
  ) u_sq_mon (
    .clk    (clk),
    .resetn (resetn),
    .sq     (sq_link)
  );

  // ---------------------------------------------------------------
  // AGC step
  // ---------------------------------------------------------------
  // Limited mode only acts over the first subcarrier pulses
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      agc_pulses <= 4'h0;
    end else if (!rx_on) begin
      agc_pulses <= 4'h0;
    end else if (dig_s2 && !dig_d && (agc_pulses != AGC_PULSES)) begin
      agc_pulses <= agc_pulses + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cur_step <= 4'h0;
    end else if (!rx_on || cmd_reset_gain) begin
      cur_step <= base_step;
    end else if (!rx_on_d) begin
      if (rx_config[RC_AGC_EN] && rx_config[RC_AGC_ALG] && (base_step < STEP_PRESET)) begin
        cur_step <= STEP_PRESET;
      end else begin
        cur_step <= base_step;
      end
    end else if (rx_config[RC_AGC_EN] && agc_hit && (cur_step != STEP_MAX) &&
                 (!rx_config[RC_AGC_M] || (agc_pulses != AGC_PULSES))) begin
      cur_step <= cur_step + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gain_state <= 4'h0;
    end else if (rx_on_d && !rx_on) begin
      gain_state <= cur_step;
    end
  end

  // ---------------------------------------------------------------
  // Analog control outputs
  // ---------------------------------------------------------------
  // window then gain from step
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dig_window_sel <= 3'h0;
      gain23_red     <= 3'h0;
    end else if (cur_step > {1'b0, WIN_MAX}) begin
      dig_window_sel <= WIN_MAX;
      gain23_red     <= 3'(cur_step - {1'b0, WIN_MAX});
    end else begin
      dig_window_sel <= cur_step[2:0];
      gain23_red     <= 3'h0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      first_gain_red   <= FG_RED_MAX;
      first_gain_boost <= 1'b0;
    end else begin
      first_gain_red   <= (first_gain_config[FG_RED_LSB +: 3] > FG_RED_MAX) ?
                          FG_RED_MAX : first_gain_config[FG_RED_LSB +: 3];
      first_gain_boost <= first_gain_config[FG_BOOST_BIT];
    end
  end

  // unused codes fall back to default
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      first_zero_sel <= Z1_60K;
      third_zero_sel <= Z3_400K;
    end else begin
      unique case (receiver_filter_config[ZERO_LSB +: 3])
        3'h4:    begin first_zero_sel <= Z1_60K; third_zero_sel <= Z3_200K; end
        3'h2:    begin first_zero_sel <= Z1_40K; third_zero_sel <= Z3_80K;  end
        3'h1:    begin first_zero_sel <= Z1_12K; third_zero_sel <= Z3_200K; end
        3'h3:    begin first_zero_sel <= Z1_12K; third_zero_sel <= Z3_80K;  end
        3'h5:    begin first_zero_sel <= Z1_12K; third_zero_sel <= Z3_200K; end
        default: begin first_zero_sel <= Z1_60K; third_zero_sel <= Z3_400K; end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lowpass_corner_sel <= LP_1200K;
    end else begin
      unique case (receiver_filter_config[LP_LSB +: 3])
        LP_600K, LP_300K, LP_2M, LP_7M:
                 lowpass_corner_sel <= receiver_filter_config[LP_LSB +: 3];
        default: lowpass_corner_sel <= LP_1200K;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr)
      ADDR_FILTER:     next_rdata = receiver_filter_config;
      ADDR_FIRST_GAIN: next_rdata = first_gain_config;
      ADDR_GAIN_CFG:   next_rdata = gain_config;
      ADDR_RX_CTRL:    next_rdata = rx_config;
      ADDR_MODE:       next_rdata = mode_config;
      ADDR_GAIN_STATE: next_rdata = {4'h0, gain_state};
      default:         next_rdata = 8'h00;
    endcase
  end

  // Data only in the cycle after the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// ---- testbench/rgf_ctrl_asserts.sv ----
// Port-level checks for the receiver gain and filter controller
`timescale 1ns/1ps
`default_nettype none
module rgf_ctrl_asserts
  import rgf_pkg::*;
(
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_rdata,
  input wire logic              mask_timer_expired,
  input wire logic              rx_on,
  input wire logic [2:0]        first_gain_red,
  input wire logic              first_gain_boost,
  input wire logic [2:0]        lowpass_corner_sel,
  input wire logic [2:0]        dig_window_sel,
  input wire logic [2:0]        gain23_red
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic       cw;
  logic       fw;
  logic       lw;
  logic [7:0] fg_d;
  logic [2:0] lp_d;

  assign cw = reg_wr && reg_addr == ADDR_COMMAND;
  assign fw = reg_wr && reg_addr == ADDR_FIRST_GAIN;
  assign lw = reg_wr && (reg_addr == ADDR_FILTER || reg_addr == ADDR_COMMAND);

  // Last written values, so a check two cycles on knows its cause
  always_ff @(posedge clk) begin
    if (fw) begin
      fg_d <= reg_wdata;
    end
    if (reg_wr && reg_addr == ADDR_FILTER) begin
      lp_d <= reg_wdata[5:3];
    end
  end

  rx_unmask_a: assert property (cw && reg_wdata == CMD_UNMASK_RX |=> rx_on)
    else $error("receive window not opened by unmask");
  rx_mask_a: assert property (cw && reg_wdata == CMD_MASK_RX |=> !rx_on)
    else $error("receive window not closed by mask");
  timer_open_a: assert property (
    mask_timer_expired && !(cw && reg_wdata == CMD_MASK_RX) |=> rx_on)
    else $error("receive window not opened by timer");
  read_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  unmapped_read_a: assert property (
    reg_rd && reg_addr inside {3'h6, 3'h7} |=> reg_rdata == 8'h00)
    else $error("unreadable index returned data");
  gain_write_a: assert property ($changed(first_gain_red) |-> $past(fw, 2))
    else $error("first gain changed without a write");
  first_gain_a: assert property (
    fw ##1 !fw |-> ##1 first_gain_boost == fg_d[3] &&
    first_gain_red == ((fg_d[2:0] > FG_RED_MAX) ? FG_RED_MAX : fg_d[2:0]))
    else $error("first gain output wrong");
  lowpass_dec_a: assert property (
    reg_wr && reg_addr == ADDR_FILTER ##1 !lw |-> ##1
    lowpass_corner_sel == ((lp_d inside {3'h2, 3'h6, 3'h7}) ? 3'h0 : lp_d))
    else $error("low-pass decode wrong");
  step_order_a: assert property (gain23_red != 3'h0 |-> dig_window_sel == WIN_MAX)
    else $error("gain cut before widest window");
  step_range_a: assert property (dig_window_sel <= WIN_MAX && gain23_red <= RED23_MAX)
    else $error("step outputs out of range");
endmodule

bind rgf_ctrl rgf_ctrl_asserts u_chk (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .mask_timer_expired(mask_timer_expired), .rx_on(rx_on), .first_gain_red(first_gain_red),
  .first_gain_boost(first_gain_boost), .lowpass_corner_sel(lowpass_corner_sel),
  .dig_window_sel(dig_window_sel), .gain23_red(gain23_red));
`default_nettype wire

// ---- testbench/rgf_ctrl_tb.sv ----
// Self-checking bench for the receiver gain and filter controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module rgf_ctrl_tb
  import rgf_pkg::*;
;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       mask_timer_expired = 1'b0;
  logic       dig = 1'b0;
  logic       tgl = 1'b0;
  logic       agc = 1'b0;
  logic [7:0] reg_rdata;
  logic       rx_on;
  logic       boost;
  logic [1:0] fz;
  logic [1:0] tz;
  logic [2:0] fg;
  logic [2:0] lp;
  logic [2:0] win;
  logic [2:0] g23;
  int         error_cnt = 0;
  int         compares = 0;
  int         n;
  logic [7:0] pm [10] = '{8'h00, 8'h01, 8'h11, 8'h21, 8'h31, 8'h41, 8'h50, 8'h02, 8'h03, 8'h04};
  logic [7:0] pe [10] = '{8'hc0, 8'hc4, 8'hc4, 8'he2, 8'he2, 8'hec, 8'hec, 8'hc5, 8'hff, 8'hff};

  always #2 clk = ~clk;
  // Noisy digitizer: many transitions per observation window
  always @(posedge clk) if (tgl) dig <= ~dig;

  // Short squelch window keeps the run brief
  rgf_ctrl #(.SQ_WIN_CYC(20)) DUT (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mask_timer_expired(mask_timer_expired), .digitizer_in(dig), .agc_comp_in(agc),
    .rx_on(rx_on), .first_gain_red(fg), .first_gain_boost(boost), .first_zero_sel(fz),
    .third_zero_sel(tz), .lowpass_corner_sel(lp), .dig_window_sel(win), .gain23_red(g23));

  // ----
  // Bus tasks and expectations
  // ----
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("rdata", e, reg_rdata)
  endtask

  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // One comparator burst inside an open receive window, then close it
  task automatic agc_burst;
    wr(ADDR_COMMAND, CMD_UNMASK_RX);
    agc <= 1'b1;
    repeat (4) @(posedge clk);
    agc <= 1'b0;
    wr(ADDR_COMMAND, CMD_MASK_RX);
    settle();
  endtask

  function automatic logic [3:0] zexp(input logic [2:0] z);
    case (z)
      3'h1, 3'h5: return {Z1_12K, Z3_200K};
      3'h2: return {Z1_40K, Z3_80K};
      3'h3: return {Z1_12K, Z3_80K};
      3'h4: return {Z1_60K, Z3_200K};
      default: return {Z1_60K, Z3_400K};
    endcase
  endfunction

  task automatic report_and_stop;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    #1;
    `CHK("gain1", FG_RED_MAX, fg)
    `CHK("window", 3'h0, win)
    rd(ADDR_FILTER, FILTER_RST);
    rd(ADDR_FIRST_GAIN, FIRST_GAIN_RST);
    rd(ADDR_GAIN_CFG, GAIN_CFG_RST);
    rd(ADDR_COMMAND, 8'h00);
    rd(3'h7, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_FILTER, {2'b00, 3'(i), 3'(i)});
      settle();
      `CHK("zeros", zexp(3'(i)), {fz, tz})
      `CHK("lowpass", (i inside {2, 6, 7}) ? 3'h0 : 3'(i), lp)
      wr(ADDR_FIRST_GAIN, {4'h0, i[0], 3'(i)});
      settle();
      `CHK("gain1", (i > 6) ? FG_RED_MAX : 3'(i), fg)
      `CHK("boost", i[0], boost)
    end
    wr(ADDR_GAIN_CFG, 8'h02);
    wr(ADDR_COMMAND, CMD_RESET_GAIN);
    settle();
    `CHK("window", 3'h2, win)
    wr(ADDR_GAIN_CFG, 8'h30);
    settle();
    `CHK("gain23", 3'h0, g23)
    wr(ADDR_COMMAND, CMD_RESET_GAIN);
    settle();
    `CHK("window", WIN_MAX, win)
    `CHK("gain23", 3'h3, g23)
    wr(ADDR_COMMAND, CMD_UNMASK_RX);
    #1;
    `CHK("rx_on", 1'b1, rx_on)
    wr(ADDR_COMMAND, CMD_MASK_RX);
    settle();
    rd(ADDR_GAIN_STATE, 8'h07);
    wr(ADDR_GAIN_STATE, 8'h00);
    rd(ADDR_GAIN_STATE, 8'h07);
    // AGC off, as for bit anticollision
    wr(ADDR_RX_CTRL, 8'h04);
    agc_burst();
    rd(ADDR_GAIN_STATE, 8'h07);
    wr(ADDR_RX_CTRL, RX_CTRL_RST);
    agc_burst();
    rd(ADDR_GAIN_STATE, 8'h08);
    @(posedge clk);
    mask_timer_expired <= 1'b1;
    @(posedge clk);
    mask_timer_expired <= 1'b0;
    #1;
    `CHK("rx_on", 1'b1, rx_on)
    wr(ADDR_COMMAND, CMD_MASK_RX);
    wr(ADDR_COMMAND, CMD_SQUELCH);
    tgl <= 1'b1;
    n = 0;
    while (g23 !== RED23_MAX && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    tgl <= 1'b0;
    if (n == 400) begin
      error_cnt++;
      report_and_stop();
    end
    #1;
    `CHK("window", WIN_MAX, win)
    wr(ADDR_COMMAND, CMD_RESET_GAIN);
    settle();
    `CHK("gain23", 3'h3, g23)
    for (int i = 0; i < 10; i++) begin
      // Filter preloaded away from every preset value
      wr(ADDR_FILTER, 8'hff);
      wr(ADDR_MODE, pm[i]);
      wr(ADDR_COMMAND, CMD_PRESET);
      settle();
      rd(ADDR_FILTER, pe[i]);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
